// file: core/bts_unit.sv
module bts_unit (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [bts_pkg::INSTR_W-1:0] instrWord,
   input wire logic [bts_pkg::DATA_W-1:0] memRdData,
   output logic cycleStart,
   output logic claimed,
   output logic [bts_pkg::ADDR_W-1:0] memAddr,
   output logic memRdEn,
   output logic memWrEn,
   output logic [bts_pkg::DATA_W-1:0] memWrData,
   output logic flush,
   output logic nopCycle,
   output logic retire
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      bts_pkg::bts_phase_t phase;
      bts_pkg::bts_dec_t cur;
      logic discard;
      logic [bts_pkg::DATA_W-1:0] readVal;
      logic testTrue;
      bts_pkg::bts_mem_t mem;
      logic cycleStart;
      logic claimed;
      logic flush;
      logic nopCycle;
      logic retire;
   } bts_state_t;

   bts_state_t st_r;
   bts_state_t st_nxt;
   bts_pkg::bts_dec_t dec;
   logic [bts_pkg::DATA_W-1:0] mask;

   bts_decode u_decode (
      .instrWord(instrWord),
      .dec(dec)
   );

   assign mask = bts_pkg::bitMask(st_r.cur.bitSel);

   // ----------------------------------------------------------------
   // next state: one instruction cycle is four ref_clk phases
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.mem.rdEn = 1'b0;
      st_nxt.mem.wrEn = 1'b0;
      st_nxt.cycleStart = 1'b0;
      st_nxt.flush = 1'b0;
      st_nxt.retire = 1'b0;
      case (st_r.phase)
         bts_pkg::BTS_PH_ISSUE: begin
            st_nxt.phase = bts_pkg::BTS_PH_READ;
            st_nxt.cycleStart = 1'b1;
            st_nxt.testTrue = 1'b0;
            st_nxt.nopCycle = st_r.discard;
            st_nxt.discard = 1'b0;
            // a discarded prefetch executes as a nop
            if (st_r.discard) begin
               st_nxt.cur.op = bts_pkg::BTS_OP_NONE;
            end else begin
               st_nxt.cur = dec;
            end
            st_nxt.claimed = !st_r.discard && (dec.op != bts_pkg::BTS_OP_NONE);
            if (!st_r.discard && (dec.op != bts_pkg::BTS_OP_NONE)) begin
               st_nxt.mem.addr = dec.fileAddr;
               st_nxt.mem.rdEn = 1'b1;
            end
         end
         bts_pkg::BTS_PH_READ: begin
            st_nxt.phase = bts_pkg::BTS_PH_EVAL;
         end
         bts_pkg::BTS_PH_EVAL: begin
            st_nxt.phase = bts_pkg::BTS_PH_COMMIT;
            st_nxt.readVal = memRdData;
            case (st_r.cur.op)
               bts_pkg::BTS_OP_SKIP_CLEAR:
                  st_nxt.testTrue = (memRdData & mask) == bts_pkg::DATA_RST;
               bts_pkg::BTS_OP_SKIP_SET:
                  st_nxt.testTrue = (memRdData & mask) != bts_pkg::DATA_RST;
               default: st_nxt.testTrue = 1'b0;
            endcase
         end
         bts_pkg::BTS_PH_COMMIT: begin
            st_nxt.phase = bts_pkg::BTS_PH_ISSUE;
            st_nxt.retire = st_r.claimed;
            case (st_r.cur.op)
               bts_pkg::BTS_OP_SET_BIT: begin
                  // only the selected bit changes; no flag path exists
                  st_nxt.mem.wrEn = 1'b1;
                  st_nxt.mem.wrData = st_r.readVal | mask;
               end
               bts_pkg::BTS_OP_SKIP_CLEAR, bts_pkg::BTS_OP_SKIP_SET: begin
                  // tests never write; they skip only on a true test
                  st_nxt.flush = st_r.testTrue;
                  st_nxt.discard = st_r.testTrue;
               end
               default: begin
                  st_nxt.discard = 1'b0;
               end
            endcase
         end
         default: begin
            st_nxt.phase = bts_pkg::BTS_PH_ISSUE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_r.phase <= bts_pkg::BTS_PH_ISSUE;
         st_r.cur.op <= bts_pkg::BTS_OP_NONE;
         st_r.cur.bitSel <= '0;
         st_r.cur.fileAddr <= bts_pkg::ADDR_RST;
         st_r.discard <= 1'b0;
         st_r.readVal <= bts_pkg::DATA_RST;
         st_r.testTrue <= 1'b0;
         st_r.mem.addr <= bts_pkg::ADDR_RST;
         st_r.mem.rdEn <= 1'b0;
         st_r.mem.wrEn <= 1'b0;
         st_r.mem.wrData <= bts_pkg::DATA_RST;
         st_r.cycleStart <= 1'b0;
         st_r.claimed <= 1'b0;
         st_r.flush <= 1'b0;
         st_r.nopCycle <= 1'b0;
         st_r.retire <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cycleStart = st_r.cycleStart;
   assign claimed = st_r.claimed;
   assign memAddr = st_r.mem.addr;
   assign memRdEn = st_r.mem.rdEn;
   assign memWrEn = st_r.mem.wrEn;
   assign memWrData = st_r.mem.wrData;
   assign flush = st_r.flush;
   assign nopCycle = st_r.nopCycle;
   assign retire = st_r.retire;

endmodule

// file: common/bts_pkg.sv
package bts_pkg;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // word layout
   // ----------------------------------------------------------------
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int SEL_W = 3;
   localparam int CLASS_MSB = 13;
   localparam int CLASS_LSB = 12;
   localparam int OP_MSB = 11;
   localparam int OP_LSB = 10;
   localparam int SEL_MSB = 9;
   localparam int SEL_LSB = 7;
   localparam int ADDR_MSB = 6;
   localparam int ADDR_LSB = 0;

   localparam logic [1:0] BIT_CLASS = 2'h1;
   localparam logic [1:0] OPC_SET = 2'h1;
   localparam logic [1:0] OPC_SKIP_CLEAR = 2'h2;
   localparam logic [1:0] OPC_SKIP_SET = 2'h3;

   // ----------------------------------------------------------------
   // timing and reset values
   // ----------------------------------------------------------------
   localparam int REF_CLK_HZ = 25_000_000;
   localparam int CLKS_PER_CYCLE = 4;
   localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BTS_OP_NONE = 2'b00,
      BTS_OP_SET_BIT = 2'b01,
      BTS_OP_SKIP_CLEAR = 2'b10,
      BTS_OP_SKIP_SET = 2'b11
   } bts_op_t;

   typedef enum logic [1:0] {
      BTS_PH_ISSUE = 2'b00,
      BTS_PH_READ = 2'b01,
      BTS_PH_EVAL = 2'b10,
      BTS_PH_COMMIT = 2'b11
   } bts_phase_t;

   typedef struct packed {
      bts_op_t op;
      logic [SEL_W-1:0] bitSel;
      logic [ADDR_W-1:0] fileAddr;
   } bts_dec_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic rdEn;
      logic wrEn;
      logic [DATA_W-1:0] wrData;
   } bts_mem_t;

   function automatic logic [DATA_W-1:0] bitMask(input logic [SEL_W-1:0] sel);
      bitMask = DATA_W'(1) << sel;
   endfunction

endpackage

// file: core/bts_decode.sv
module bts_decode (
   input wire logic [bts_pkg::INSTR_W-1:0] instrWord,
   output bts_pkg::bts_dec_t dec
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] opField;

   assign opField = instrWord[bts_pkg::OP_MSB:bts_pkg::OP_LSB];

   always_comb begin
      dec.bitSel = instrWord[bts_pkg::SEL_MSB:bts_pkg::SEL_LSB];
      dec.fileAddr = instrWord[bts_pkg::ADDR_MSB:bts_pkg::ADDR_LSB];
      dec.op = bts_pkg::BTS_OP_NONE;
      if (instrWord[bts_pkg::CLASS_MSB:bts_pkg::CLASS_LSB] == bts_pkg::BIT_CLASS) begin
         case (opField)
            bts_pkg::OPC_SKIP_CLEAR: dec.op = bts_pkg::BTS_OP_SKIP_CLEAR;
            bts_pkg::OPC_SKIP_SET: dec.op = bts_pkg::BTS_OP_SKIP_SET;
            bts_pkg::OPC_SET: dec.op = bts_pkg::BTS_OP_SET_BIT;
            default: dec.op = bts_pkg::BTS_OP_NONE;
         endcase
      end
   end

endmodule

// file: sim/bts_unit_assertions.sv
module bts_unit_assertions (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [bts_pkg::INSTR_W-1:0] instrWord,
   input wire logic [bts_pkg::DATA_W-1:0] memRdData,
   input wire logic cycleStart,
   input wire logic claimed,
   input wire logic [bts_pkg::ADDR_W-1:0] memAddr,
   input wire logic memRdEn,
   input wire logic memWrEn,
   input wire logic [bts_pkg::DATA_W-1:0] memWrData,
   input wire logic flush,
   input wire logic nopCycle,
   input wire logic retire
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   cycle_period_a: assert property (cycleStart |=>
      !cycleStart ##1 !cycleStart ##1 !cycleStart ##1 cycleStart)
      else $error("cycle start spacing wrong");
   read_on_claim_a: assert property (cycleStart && claimed |-> memRdEn)
      else $error("claimed op without read");
   read_cause_a: assert property (memRdEn |-> claimed && cycleStart)
      else $error("read without claimed op");
   addr_field_a: assert property (memRdEn |-> memAddr == $past(instrWord[6:0]))
      else $error("file address not taken from word");
   set_value_a: assert property (memWrEn |-> memWrData == ($past(memRdData, 2)
      | (8'h01 << $past(instrWord[9:7], 4)))) else $error("set write data wrong");
   write_alone_a: assert property (memWrEn |-> retire && !flush)
      else $error("write with flush or no retire");
   flush_nop_a: assert property (flush |->
      retire ##1 (cycleStart && nopCycle && !claimed))
      else $error("flush not followed by nop cycle");
   nop_quiet_a: assert property (nopCycle |->
      !memRdEn && !memWrEn && !claimed)
      else $error("nop cycle touched memory");
   retire_time_a: assert property (retire |-> $past(memRdEn, 3))
      else $error("retire not three clocks after read");

   cover property (flush);
   cover property (memWrEn);
   cover property (retire && !flush && !memWrEn);
   cover property (nopCycle && cycleStart);
endmodule

bind bts_unit bts_unit_assertions u_chk (.ref_clk, .resetn, .instrWord, .memRdData,
   .cycleStart, .claimed, .memAddr, .memRdEn, .memWrEn, .memWrData, .flush, .nopCycle, .retire);

// file: sim/bts_unit_tb_top.sv
module bts_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // stimulus and checks
   // ----------------------------------------------------------------
   int mismatches = 0;
   int total_checks = 0;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [13:0] instrWord = 14'h0000;
   logic [7:0] memRdData = 8'h00;
   logic cycleStart, claimed, memRdEn, memWrEn, flush, nopCycle, retire;
   logic [6:0] memAddr;
   logic [7:0] memWrData;
   logic pendNop = 1'b0;

   bts_unit uut (.ref_clk, .resetn, .instrWord, .memRdData, .cycleStart, .claimed, .memAddr,
      .memRdEn, .memWrEn, .memWrData, .flush, .nopCycle, .retire);

   initial forever #20 ref_clk = ~ref_clk;

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results;
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic expClaim(input logic [13:0] w);
      return w[13:12] == 2'h1 && w[11:10] != 2'h0;
   endfunction

   function automatic logic expSkip(input logic [13:0] w, input logic [7:0] d);
      return expClaim(w) && w[11] && (d[w[9:7]] == w[10]);
   endfunction

   // one instruction cycle: word and read data held for all four clocks
   task automatic runInstr(input logic [13:0] w, input logic [7:0] d);
      logic rd, wr, fl, rt, cl, nop, ok;
      logic [7:0] wd;
      logic [6:0] ad;
      logic [3:0] cs;
      {rd, wr, fl, rt} = 4'h0;
      cs = 4'h0;
      wd = 8'h00;
      instrWord = w;
      memRdData = d;
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         @(negedge ref_clk);
         if (i == 0) {cl, nop, ad} = {claimed, nopCycle, memAddr};
         cs[i] = cycleStart;
         rd |= memRdEn;
         wr |= memWrEn;
         fl |= flush;
         rt |= retire;
         if (memWrEn) wd = memWrData;
      end
      ok = expClaim(w) && !pendNop;
      check("cycleStart", {4'h0, cs}, 8'h01);
      check("claimed", cl, ok);
      check("nopCycle", nop, pendNop);
      check("memRdEn", rd, ok);
      if (ok) check("memAddr", ad, w[6:0]);
      check("memWrEn", wr, ok && w[11:10] == 2'h1);
      if (wr) check("memWrData", wd, d | (8'h01 << w[9:7]));
      check("flush", fl, ok && expSkip(w, d));
      check("retire", rt, ok);
      pendNop = ok && expSkip(w, d);
   endtask

   initial begin
      logic [13:0] w;
      void'($urandom(32'hc64a));
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      runInstr({2'h1, 2'h2, 3'h0, 7'h7f}, 8'hfe);
      runInstr({2'h1, 2'h1, 3'h7, 7'h00}, 8'h0a);
      runInstr({2'h1, 2'h3, 3'h7, 7'h40}, 8'h80);
      runInstr({2'h1, 2'h3, 3'h7, 7'h40}, 8'h80);
      runInstr({2'h1, 2'h1, 3'h7, 7'h12}, 8'h0a);
      runInstr({2'h1, 2'h0, 3'h2, 7'h05}, 8'h00);
      runInstr({2'h1, 2'h2, 3'h3, 7'h05}, 8'h08);
      runInstr({2'h1, 2'h3, 3'h3, 7'h05}, 8'hf7);
      repeat (300) begin
         w = 14'($urandom);
         if ($urandom % 4 != 0) w[13:12] = 2'h1;
         runInstr(w, 8'($urandom));
      end
      results;
   end

   initial begin
      #200_000;
      mismatches++;
      results;
   end
endmodule
